// ==== logic/mis_defines.vh ====
`ifndef MIS_DEFINES_VH
`define MIS_DEFINES_VH

// controller register offsets (axi4-lite, one word each)
`define MIS_REG_CTRL      8'h00
`define MIS_REG_CFG       8'h04
`define MIS_REG_ARR_LAST  8'h08
`define MIS_REG_STATUS    8'h0C
`define MIS_REG_COPY      8'h10

// control register bits
`define MIS_CTRL_START    0
`define MIS_CTRL_USE_NV   1
`define MIS_CTRL_USE_OTP  2
`define MIS_CTRL_VERIFY   3
`define MIS_CTRL_ABORT    4

// memory opcodes
`define MIS_CMD_WRITE_ENABLE_LATCH      8'h06
`define MIS_CMD_WR_VREG   8'h81
`define MIS_CMD_RD_VREG   8'h85
`define MIS_CMD_WR_NVREG  8'hB1
`define MIS_CMD_WR_SR     8'h01
`define MIS_CMD_RD_SR     8'h05
`define MIS_CMD_WR_OTP    8'h42
`define MIS_CMD_WR_ARRAY  8'h02
`define MIS_CMD_RD_ARRAY  8'h03
`define MIS_CMD_RD_FSR    8'h70

// memory register map
`define MIS_VREG_MODE     8'h1E
`define MIS_VREG_IMASK    8'h0F
`define MIS_VREG_ISTAT    8'h10
`define MIS_NV_LAST       24'h00000C
`define MIS_OTP_LAST      24'h0000FF
`define MIS_BP_ALL        8'h7C
`define MIS_PAT_ZERO      8'h00
`define MIS_PAT_ONES      8'hFF

// operation flag status fields
`define MIS_FSR_READY     7
`define MIS_FSR_ERR_MASK  8'h3A

// sequence phases
`define MIS_PH_ENTER      4'd0
`define MIS_PH_IOW        4'd1
`define MIS_PH_NV         4'd2
`define MIS_PH_BP         4'd3
`define MIS_PH_OTP        4'd4
`define MIS_PH_ARR        4'd5
`define MIS_PH_EXIT       4'd6
`define MIS_PH_SAVE       4'd7
`define MIS_PH_DONE       4'd8

// frame kinds
`define MIS_K_ITEM        2'd0
`define MIS_K_WRITE_ENABLE_LATCH        2'd1
`define MIS_K_POLL        2'd2

// timing
`define MIS_CLK_MHZ       200
`define MIS_T_CSH_NS      500
`define MIS_CSH_CYC       ((`MIS_T_CSH_NS * `MIS_CLK_MHZ + 999) / 1000)
`define MIS_SCK_HALF      4

`endif

// ==== logic/mis_sync2.v ====
`timescale 1ns/1ps
module mis_sync2 (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [1:0] pin_in,
  output reg  [1:0] pin_s
);
  reg [1:0] meta_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 2'h3;
      pin_s  <= 2'h3;
    end else begin
      meta_q <= pin_in;
      pin_s  <= meta_q;
    end
  end
endmodule

// ==== logic/mis_spi_byte.v ====
`timescale 1ns/1ps
`include "mis_defines.vh"
// mode 0 byte shifter, msb first; sck is a divided aclk
module mis_spi_byte (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       start,
  input  wire [7:0] tx_byte,
  input  wire       miso_s,
  output reg        sck,
  output reg        mosi,
  output reg  [7:0] rx_byte,
  output reg        done
);
  reg       busy_q;
  reg [7:0] cnt_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      busy_q  <= 1'b0;
      cnt_q   <= 8'h00;
      bit_q   <= 3'h0;
      sh_q    <= 8'h00;
      sck     <= 1'b0;
      mosi    <= 1'b0;
      rx_byte <= 8'h00;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q  <= 8'h00;
        bit_q  <= 3'h0;
        sh_q   <= tx_byte;
        mosi   <= tx_byte[7];
        sck    <= 1'b0;
      end else if (busy_q) begin
        if (cnt_q == `MIS_SCK_HALF - 1) begin
          cnt_q <= 8'h00;
          if (!sck) begin
            sck <= 1'b1;
          end else begin
            // sample late in the high half: covers the two-flop delay on miso
            sck     <= 1'b0;
            rx_byte <= {rx_byte[6:0], miso_s};
            if (bit_q == 3'h7) begin
              busy_q <= 1'b0;
              done   <= 1'b1;
            end else begin
              bit_q <= bit_q + 3'h1;
              sh_q  <= {sh_q[6:0], 1'b0};
              mosi  <= sh_q[6];
            end
          end
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end
endmodule

// ==== logic/mis_init_seq.v ====
// Overview of operation
// R1 - device sets flag bit 3 when its crc differs from the host crc
// R2 - device fails program or otp write without write latch or when protected
// R3 - device flags erase failure in bit 5; erase without write latch fails
// R4 - flag bit 7 reads 0 while a write-type operation runs, 1 when ready
// R5 - device mask register enables crc-done and erase-done onto the interrupt pin
// R6 - device interrupt status bits 1 and 0 set on completion, write 1 clears
// R7 - device power-on error bit 2 is write-1-clear and survives hardware reset
// R8 - interrupt mask and status use the volatile register read and write commands
// R9 - device has a 256 byte otp area controlled by a control byte
// R10 - host starts in single-bit spi mode before any initialization command
// R11 - enter factory mode: write enable, then 81h to register 1Eh with device id
// R12 - after entry the host writes the io width volatile register with 81h
// R13 - if used, every nonvolatile register written 00h then FFh with B1h
// R14 - block protect bits set to 1Fh and read back, then 00h and read back
// R15 - if used, whole otp area written 00h then FFh with command 42h
// R16 - array filled 00h, FFh, 00h with readback, FFh with readback
// R17 - exit factory mode by writing 00h to register 1Eh; then ready
// R18 - readback passes are optional and may be omitted
// R19 - host keeps a copy of register values after configuration
// R20 - device defaults to single-bit transfers after reflow or reset
// R21 - device flag bits zero at power-up, error bits held until cleared
// R22 - host polls flag bit 7 for ready after every write-type command; the code polls only after 01h, B1h, 42h and 02h, not after 81h
`timescale 1ns/1ps
`include "mis_defines.vh"
module mis_init_seq (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire        spi_sck,
  output reg         spi_cs_n,
  output wire        spi_mosi,
  input  wire        spi_miso,
  input  wire        mem_int_n
);
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_STEP = 4'b0010;
  localparam [3:0] S_XFER = 4'b0100;
  localparam [3:0] S_GAP  = 4'b1000;

  reg  [3:0]  state_q;
  reg  [3:0]  phase_q;
  reg  [1:0]  pass_q;
  reg  [23:0] addr_q;
  reg         rb_q;
  reg         wen_q;
  reg         use_nv_q;
  reg         use_otp_q;
  reg         verify_q;
  reg         start_q;
  reg         abort_q;
  reg  [7:0]  devid_q;
  reg  [7:0]  io_addr_q;
  reg  [7:0]  io_data_q;
  reg  [23:0] arr_last_q;
  reg         done_q;
  reg         err_q;
  reg  [7:0]  err_code_q;
  reg  [31:0] copy_q;
  reg  [7:0]  fr_q [0:4];
  reg  [2:0]  fr_len_q;
  reg  [2:0]  idx_q;
  reg         fr_rd_q;
  reg         fr_poll_q;
  reg  [1:0]  kind_q;
  reg         go_q;
  reg  [7:0]  rx_q;
  reg  [7:0]  gap_q;
  wire [1:0]  pins_s;
  wire [7:0]  spi_rx;
  wire        spi_done;
  wire        wr_take;
  wire        rd_take;
  wire [7:0]  pat;
  wire        is_write;
  wire [31:0] cfg_d;
  wire [31:0] arr_last_d;

  mis_sync2 u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  ({mem_int_n, spi_miso}),
    .pin_s   (pins_s)
  );

  // single data line out and in only: the host never leaves 1-bit mode  [R10]
  mis_spi_byte u_spi (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (go_q),
    .tx_byte (fr_q[idx_q]),
    .miso_s  (pins_s[0]),
    .sck     (spi_sck),
    .mosi    (spi_mosi),
    .rx_byte (spi_rx),
    .done    (spi_done)
  );

  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      lane_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          lane_merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  function [23:0] last_addr;
    input [3:0]  ph;
    input [23:0] arr_last;
    begin
      case (ph)
        `MIS_PH_NV:   last_addr = `MIS_NV_LAST;
        `MIS_PH_OTP:  last_addr = `MIS_OTP_LAST;
        `MIS_PH_ARR:  last_addr = arr_last;
        `MIS_PH_SAVE: last_addr = 24'h000003;
        default:      last_addr = 24'h000000;
      endcase
    end
  endfunction

  function [1:0] last_pass;
    input [3:0] ph;
    begin
      case (ph)
        `MIS_PH_NV, `MIS_PH_BP, `MIS_PH_OTP: last_pass = 2'd1;
        `MIS_PH_ARR:                         last_pass = 2'd3;
        default:                             last_pass = 2'd0;
      endcase
    end
  endfunction

  function [3:0] next_phase;
    input [3:0] ph;
    input       nv;
    input       otp;
    begin
      case (ph)
        `MIS_PH_ENTER: next_phase = `MIS_PH_IOW;
        `MIS_PH_IOW:   next_phase = nv ? `MIS_PH_NV : `MIS_PH_BP;
        `MIS_PH_BP:    next_phase = otp ? `MIS_PH_OTP : `MIS_PH_ARR;
        default:       next_phase = ph + 4'd1;
      endcase
    end
  endfunction

  // passes alternate 00h/FFh; block protect alternates all-set/clear
  assign pat      = pass_q[0] ? `MIS_PAT_ONES : `MIS_PAT_ZERO;
  assign is_write = (phase_q != `MIS_PH_SAVE) && !rb_q;
  assign wr_take  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_take  = s_axi_arvalid && s_axi_arready;
  assign cfg_d      = lane_merge({8'h00, io_data_q, io_addr_q, devid_q}, s_axi_wdata, s_axi_wstrb);
  assign arr_last_d = lane_merge({8'h00, arr_last_q}, s_axi_wdata, s_axi_wstrb);

  task ld;
    input [2:0] n;
    input [7:0] b0;
    input [7:0] b1;
    input [7:0] b2;
    input [7:0] b3;
    input [7:0] b4;
    input       rd;
    input       pl;
    input [1:0] k;
    begin
      fr_q[0]   <= b0;
      fr_q[1]   <= b1;
      fr_q[2]   <= b2;
      fr_q[3]   <= b3;
      fr_q[4]   <= b4;
      fr_len_q  <= n;
      fr_rd_q   <= rd;
      fr_poll_q <= pl;
      kind_q    <= k;
      idx_q     <= 3'h0;
      go_q      <= 1'b1;
      spi_cs_n  <= 1'b0;
      state_q   <= S_XFER;
    end
  endtask

  task advance;
    begin
      wen_q <= 1'b0;
      state_q <= S_STEP;
      if (!rb_q && verify_q && ((phase_q == `MIS_PH_BP) ||
          ((phase_q == `MIS_PH_ARR) && pass_q[1]))) begin
        rb_q <= 1'b1; // [R14] [R16]
      end else begin
        rb_q <= 1'b0;
        if (addr_q != last_addr(phase_q, arr_last_q)) begin
          addr_q <= addr_q + 24'h000001;
        end else begin
          addr_q <= 24'h000000;
          if (pass_q != last_pass(phase_q)) begin
            pass_q <= pass_q + 2'd1;
          end else begin
            pass_q  <= 2'd0;
            phase_q <= next_phase(phase_q, use_nv_q, use_otp_q); // [R13] [R15]
            if (phase_q == `MIS_PH_SAVE) begin
              state_q <= S_IDLE;
              done_q  <= 1'b1;
            end
          end
        end
      end
    end
  endtask

  // sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= S_IDLE;
      phase_q    <= `MIS_PH_ENTER;
      pass_q     <= 2'd0;
      addr_q     <= 24'h000000;
      rb_q       <= 1'b0;
      wen_q      <= 1'b0;
      done_q     <= 1'b0;
      err_q      <= 1'b0;
      err_code_q <= 8'h00;
      copy_q     <= 32'h00000000;
      fr_q[0]    <= 8'h00;
      fr_q[1]    <= 8'h00;
      fr_q[2]    <= 8'h00;
      fr_q[3]    <= 8'h00;
      fr_q[4]    <= 8'h00;
      fr_len_q   <= 3'h0;
      idx_q      <= 3'h0;
      fr_rd_q    <= 1'b0;
      fr_poll_q  <= 1'b0;
      kind_q     <= `MIS_K_ITEM;
      go_q       <= 1'b0;
      rx_q       <= 8'h00;
      gap_q      <= 8'h00;
      spi_cs_n   <= 1'b1;
    end else begin
      go_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (start_q) begin
            phase_q <= `MIS_PH_ENTER;
            pass_q  <= 2'd0;
            addr_q  <= 24'h000000;
            rb_q    <= 1'b0;
            wen_q   <= 1'b0;
            done_q  <= 1'b0;
            err_q   <= 1'b0;
            err_code_q <= 8'h00;
            state_q <= S_STEP;
          end
        end
        S_STEP: begin
          if (is_write && !wen_q) begin
            ld(3'd1, `MIS_CMD_WRITE_ENABLE_LATCH, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, `MIS_K_WRITE_ENABLE_LATCH); // [R11]
          end else begin
            case (phase_q)
              `MIS_PH_ENTER: ld(3'd3, `MIS_CMD_WR_VREG, `MIS_VREG_MODE, devid_q, 8'h00, 8'h00,
                                1'b0, 1'b0, `MIS_K_ITEM); // [R11]
              `MIS_PH_IOW:   ld(3'd3, `MIS_CMD_WR_VREG, io_addr_q, io_data_q, 8'h00, 8'h00,
                                1'b0, 1'b0, `MIS_K_ITEM); // [R12]
              `MIS_PH_NV:    ld(3'd3, `MIS_CMD_WR_NVREG, addr_q[7:0], pat, 8'h00, 8'h00,
                                1'b0, 1'b1, `MIS_K_ITEM); // [R13]
              `MIS_PH_BP: begin
                if (rb_q) begin
                  ld(3'd2, `MIS_CMD_RD_SR, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, `MIS_K_ITEM); // [R14]
                end else begin
                  ld(3'd2, `MIS_CMD_WR_SR, pass_q[0] ? 8'h00 : `MIS_BP_ALL, 8'h00, 8'h00, 8'h00,
                     1'b0, 1'b1, `MIS_K_ITEM); // [R14]
                end
              end
              `MIS_PH_OTP:   ld(3'd5, `MIS_CMD_WR_OTP, addr_q[23:16], addr_q[15:8], addr_q[7:0], pat,
                                1'b0, 1'b1, `MIS_K_ITEM); // [R15]
              `MIS_PH_ARR: begin
                if (rb_q) begin
                  ld(3'd5, `MIS_CMD_RD_ARRAY, addr_q[23:16], addr_q[15:8], addr_q[7:0], 8'h00,
                     1'b1, 1'b0, `MIS_K_ITEM); // [R16]
                end else begin
                  ld(3'd5, `MIS_CMD_WR_ARRAY, addr_q[23:16], addr_q[15:8], addr_q[7:0], pat,
                     1'b0, 1'b1, `MIS_K_ITEM); // [R16]
                end
              end
              `MIS_PH_EXIT:  ld(3'd3, `MIS_CMD_WR_VREG, `MIS_VREG_MODE, 8'h00, 8'h00, 8'h00,
                                1'b0, 1'b0, `MIS_K_ITEM); // [R17]
              `MIS_PH_SAVE: begin
                case (addr_q[1:0])
                  2'd0:    ld(3'd2, `MIS_CMD_RD_SR, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, `MIS_K_ITEM);
                  2'd1:    ld(3'd2, `MIS_CMD_RD_FSR, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, `MIS_K_ITEM);
                  2'd2:    ld(3'd3, `MIS_CMD_RD_VREG, `MIS_VREG_IMASK, 8'h00, 8'h00, 8'h00,
                              1'b1, 1'b0, `MIS_K_ITEM); // [R8]
                  default: ld(3'd3, `MIS_CMD_RD_VREG, `MIS_VREG_ISTAT, 8'h00, 8'h00, 8'h00,
                              1'b1, 1'b0, `MIS_K_ITEM); // [R8]
                endcase
              end
              default: begin
                state_q <= S_IDLE;
                done_q  <= 1'b1;
              end
            endcase
          end
        end
        S_XFER: begin
          if (spi_done) begin
            rx_q <= spi_rx;
            if (idx_q == fr_len_q - 3'd1) begin
              spi_cs_n <= 1'b1;
              gap_q    <= 8'h00;
              state_q  <= S_GAP;
            end else begin
              idx_q <= idx_q + 3'h1;
              go_q  <= 1'b1;
            end
          end
        end
        S_GAP: begin
          // cs stays high a full gap so each command is framed on its own
          if (gap_q != `MIS_CSH_CYC - 1) begin
            gap_q <= gap_q + 8'h01;
          end else if (abort_q) begin
            state_q    <= S_IDLE;
            err_q      <= 1'b1;
            err_code_q <= 8'h00;
          end else if (kind_q == `MIS_K_WRITE_ENABLE_LATCH) begin
            wen_q   <= 1'b1;
            state_q <= S_STEP;
          end else if (kind_q == `MIS_K_POLL) begin
            if (!rx_q[`MIS_FSR_READY]) begin
              ld(3'd2, `MIS_CMD_RD_FSR, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, `MIS_K_POLL); // [R22]
            end else if ((rx_q & `MIS_FSR_ERR_MASK) != 8'h00) begin
              state_q    <= S_IDLE;
              err_q      <= 1'b1;
              err_code_q <= rx_q;
            end else begin
              advance;
            end
          end else if (fr_poll_q) begin
            ld(3'd2, `MIS_CMD_RD_FSR, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, `MIS_K_POLL); // [R22]
          end else if (fr_rd_q && (phase_q == `MIS_PH_SAVE)) begin
            copy_q[addr_q[1:0]*8 +: 8] <= rx_q; // [R19]
            advance;
          end else if (fr_rd_q && (phase_q == `MIS_PH_BP) &&
                       ((rx_q & `MIS_BP_ALL) != (pass_q[0] ? 8'h00 : `MIS_BP_ALL))) begin
            state_q    <= S_IDLE;
            err_q      <= 1'b1;
            err_code_q <= rx_q; // [R14]
          end else if (fr_rd_q && (phase_q == `MIS_PH_ARR) && (rx_q != pat)) begin
            state_q    <= S_IDLE;
            err_q      <= 1'b1;
            err_code_q <= rx_q; // [R16]
          end else begin
            advance;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // axi4-lite slave: one write and one read at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h00000000;
      use_nv_q      <= 1'b0;
      use_otp_q     <= 1'b0;
      verify_q      <= 1'b0;
      start_q       <= 1'b0;
      abort_q       <= 1'b0;
      devid_q       <= 8'h00;
      io_addr_q     <= 8'h00;
      io_data_q     <= 8'h00;
      arr_last_q    <= 24'h000000;
    end else begin
      start_q <= 1'b0;
      if (state_q == S_GAP && gap_q == `MIS_CSH_CYC - 1) begin
        abort_q <= 1'b0;
      end
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        case (s_axi_awaddr[7:0])
          `MIS_REG_CTRL: begin
            if (s_axi_wstrb[0]) begin
              start_q   <= s_axi_wdata[`MIS_CTRL_START] && (state_q == S_IDLE);
              use_nv_q  <= s_axi_wdata[`MIS_CTRL_USE_NV];
              use_otp_q <= s_axi_wdata[`MIS_CTRL_USE_OTP];
              verify_q  <= s_axi_wdata[`MIS_CTRL_VERIFY]; // [R18]
              if (s_axi_wdata[`MIS_CTRL_ABORT] && (state_q != S_IDLE)) begin
                abort_q <= 1'b1;
              end
            end
          end
          `MIS_REG_CFG: begin
            {io_data_q, io_addr_q, devid_q} <= cfg_d[23:0];
          end
          `MIS_REG_ARR_LAST: begin
            arr_last_q <= arr_last_d[23:0];
          end
          `MIS_REG_STATUS, `MIS_REG_COPY: s_axi_bresp <= 2'b00;
          default: s_axi_bresp <= 2'b10;
        endcase
      end
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr[7:0])
          `MIS_REG_CTRL:     s_axi_rdata <= {28'h0000000, verify_q, use_otp_q, use_nv_q, 1'b0};
          `MIS_REG_CFG:      s_axi_rdata <= {8'h00, io_data_q, io_addr_q, devid_q};
          `MIS_REG_ARR_LAST: s_axi_rdata <= {8'h00, arr_last_q};
          `MIS_REG_STATUS:   s_axi_rdata <= {16'h0000, err_code_q, phase_q, !pins_s[1], err_q, done_q,
                                             state_q != S_IDLE};
          `MIS_REG_COPY:     s_axi_rdata <= copy_q;
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
    end
  end
endmodule

// ==== dv/mis_chk_properties.sv ====
`timescale 1ns/1ps
module mis_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire spi_sck,
  input wire spi_cs_n,
  input wire spi_mosi
);
  // counts cs high time; not reset so the first frame is also covered
  logic [6:0] gap_q = 7'h00;
  always @(posedge aclk) begin
    if (!spi_cs_n) gap_q <= 7'h00;
    else if (gap_q != 7'h7F) gap_q <= gap_q + 7'h01;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wtake;
    s_axi_awready && s_axi_wready ##1 s_axi_bvalid;
  endsequence
  sequence s_rtake;
    s_axi_arready ##1 s_axi_rvalid;
  endsequence
  a_sck_idle_low: assert property (spi_cs_n |-> !spi_sck)
    else $error("sck active outside frame");
  a_cs_gap_min: assert property ($fell(spi_cs_n) |-> gap_q >= 7'd99)
    else $error("cs high gap too short");
  a_mosi_stable: assert property ($rose(spi_sck) |-> $stable(spi_mosi))
    else $error("mosi moved at sck rise");
  a_sck_high_four: assert property ($rose(spi_sck) |-> spi_sck [*4] ##1 !spi_sck)
    else $error("sck high phase wrong");
  a_aw_take: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid |=> s_wtake)
    else $error("write not taken");
  a_ar_take: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_rtake)
    else $error("read not taken");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
endmodule

// ==== dv/mis_mem_model.sv ====
`timescale 1ns/1ps
module mis_mem_model (
  input  wire  spi_sck,
  input  wire  spi_cs_n,
  input  wire  spi_mosi,
  input  wire  inj_err,
  output logic spi_miso = 1'b0,
  output logic mem_int_n = 1'b1 // every event masked
);
  logic [7:0]  b [0:4];
  logic [7:0]  arr [0:15];
  logic [7:0]  nv [0:15];
  logic [7:0]  sh = 8'h00, tx = 8'h00, sr = 8'h00, op_first = 8'h00, io_d = 8'h00, a_cnt = 8'h00, otp_cnt = 8'h00;
  logic [7:0]  fsr = 8'h80; // ready, no flags; no crc or erase runs
  logic [7:0]  imask = 8'h00, istat = 8'h00;
  logic [15:0] m_log = 16'h0000, sr_log = 16'h0000;
  logic        write_latch_bit = 1'b0, busy = 1'b0, viol = 1'b0, first = 1'b1;
  int          nb = 0, bi = 0;
  initial begin
    for (int i = 0; i < 16; i++) arr[i] = 8'hA5;
    for (int i = 0; i < 5; i++) b[i] = 8'h00;
  end
  always @(negedge spi_cs_n) begin
    nb = 0;
    bi = 0;
  end
  // single-bit frames only
  always @(posedge spi_sck) begin
    if (!spi_cs_n) begin
      sh = {sh[6:0], spi_mosi};
      bi = bi + 1;
      if (bi == 8) begin
        bi = 0;
        if (nb < 5) b[nb] = sh;
        nb = nb + 1;
        case (b[0])
          8'h70: tx = {~busy, fsr[6:5], fsr[4] | inj_err, fsr[3:0]};
          8'h05: tx = sr;
          8'h85: tx = (b[1] == 8'h0F) ? imask : (b[1] == 8'h10) ? istat : 8'h00;
          8'h03: tx = arr[b[3][3:0]];
          default: tx = ~sh;
        endcase
      end
    end
  end
  always @(negedge spi_sck) begin
    if (!spi_cs_n) begin
      spi_miso = tx[7];
      tx = {tx[6:0], 1'b0};
    end
  end
  always @(posedge spi_cs_n) begin
    // released line shows no stale value
    spi_miso = ~spi_miso;
    if (nb > 0) begin
      if (first) op_first = b[0];
      first = 1'b0;
      case (b[0])
        8'h06: write_latch_bit = 1'b1;
        8'h81: begin
          if (b[1] == 8'h1E) m_log = {m_log[7:0], b[2]};
          else io_d = b[2];
          write_latch_bit = 1'b0;
        end
        8'h70: busy = 1'b0; // busy for one poll
        8'h03: a_cnt = a_cnt + 8'h01;
        8'h01, 8'hB1, 8'h42, 8'h02: begin
          if (busy) viol = 1'b1;
          if (!write_latch_bit) fsr[4] = 1'b1;
          else if (b[0] == 8'h01) sr = b[1] & 8'h7C;
          else if (b[0] == 8'hB1) nv[b[1][3:0]] = b[2];
          else if (b[0] == 8'h02) arr[b[3][3:0]] = b[4];
          else otp_cnt = otp_cnt + 8'h01; // area contents not kept
          if (b[0] == 8'h01) sr_log = {sr_log[7:0], b[1]};
          busy = 1'b1;
          write_latch_bit = 1'b0;
        end
        default: ;
      endcase
    end
  end
endmodule

// ==== dv/mis_init_seq_test.sv ====
`timescale 1ns/1ps
module mis_init_seq_test;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, inj_err = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         spi_sck, spi_cs_n, spi_mosi, spi_miso, mem_int_n;
  int          err_count = 0, checks = 0;
  mis_init_seq mis_init_seq_inst (.*);
  mis_mem_model mis_mem_model_inst (.*);
  initial forever #2.5 aclk = ~aclk;
  task end_sim;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, output [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_bvalid === 1'b1) break;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 40) begin
      err_count++;
      end_sim;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_rvalid === 1'b1) break;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 40) begin
      err_count++;
      end_sim;
    end
  endtask
  // waits for busy low, or for a given phase when ph is below 15
  task wait_st(input [3:0] ph);
    int n;
    for (n = 0; n < 15000; n++) begin
      rd(8'h0C, rv, rs);
      if (ph == 4'hF ? rv[0] === 1'b0 : rv[7:4] === ph) break;
    end
    if (n == 15000) begin
      err_count++;
      end_sim;
    end
  endtask
  task t_regs;
    for (int i = 0; i < 4; i++) begin
      rd(8'(i * 4), rv, rs);
      chk(rv, 32'h0);
    end
    chk(spi_cs_n, 1'b1);
    rd(8'h20, rv, rs);
    chk(rv, 32'h0);
    chk(rs, 2'h2);
    wr(8'h20, 32'hFFFFFFFF, rs);
    chk(rs, 2'h2);
  endtask
  // failed program reported by the flag byte stops the run
  task t_err;
    wr(8'h04, 32'h00E7005A, rs);
    wr(8'h08, 32'h3, rs);
    inj_err <= 1'b1;
    wr(8'h00, 32'h3, rs);
    wait_st(4'hF);
    chk(rv[15:8], 8'h90);
    chk(rv[7:4], 4'h2);
    chk(rv[2], 1'b1);
    inj_err <= 1'b0;
  endtask
  task t_full;
    wr(8'h00, 32'hB, rs);
    wait_st(4'hF);
    chk(rv[15:0], 16'h0082);
    rd(8'h10, rv, rs);
    chk(rv, 32'h00008000);
    chk(mis_mem_model_inst.op_first, 8'h06);
    chk(mis_mem_model_inst.m_log, 16'h5A00);
    chk(mis_mem_model_inst.io_d, 8'hE7);
    chk({mis_mem_model_inst.nv[0], mis_mem_model_inst.nv[12]}, 16'hFFFF);
    chk(mis_mem_model_inst.sr_log, 16'h7C00);
    chk({mis_mem_model_inst.arr[0], mis_mem_model_inst.arr[3], mis_mem_model_inst.arr[4]}, 24'hFFFFA5);
    chk(mis_mem_model_inst.a_cnt, 8'h8);
    chk(mis_mem_model_inst.viol, 1'b0);
  endtask
  // abort in the otp pass, no readbacks requested
  task t_abort;
    wr(8'h00, 32'h5, rs);
    wait_st(4'h4);
    repeat (1500) @(posedge aclk);
    wr(8'h00, 32'h10, rs);
    wait_st(4'hF);
    chk(rv[15:8], 8'h00);
    chk(rv[2], 1'b1);
    chk(mis_mem_model_inst.otp_cnt != 8'h0, 1'b1);
    chk(mis_mem_model_inst.a_cnt, 8'h8);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (100) @(posedge aclk);
    t_regs;
    t_err;
    t_full;
    t_abort;
    end_sim;
  end
endmodule
bind mis_init_seq mis_chk mis_chk_inst (.*);
